// File: logic/pced_top.sv
// Pin change edge detector with AXI4-Lite register slave and interrupt logic
// Functional notes
// - Port A bits 5:3,1:0 detect rising edges only when rise enable bit set.
// - Port A bits 5:3,1:0 detect falling edges only when fall enable bit set.
// - Port B bits 7:4 detect rising edges only when rise enable bit set.
// - Port B bits 7:4 detect falling edges only when fall enable bit set.
// - Enabled rising or falling edge sets the pin flag; both enables allow either.
// - With both enables clear, pin activity never sets that pin's flag.
// - Any enabled edge setting a pin flag also sets the summary flag.
// - Flags set by hardware, software may read and write, zero clears.
// - Flag one means enabled change seen; zero means none or cleared.
// - Unimplemented bits of enable and flag registers always read zero.
// - All enable and flag bits reset to zero.
// - Summary flag is OR of all pin flags, falls when all cleared.
// - Detection continues regardless of interrupt enable; enable gates only the request.
// - Edge during a clearing write leaves the flag set.
// - With interrupt enable set, an enabled edge raises wake after flags update.
`timescale 1ns/1ps
module pced_top #(
  parameter bit HAS_PORTB = 1'b1
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [7:0]                 porta_pin,
  input  wire logic [7:0]                 portb_pin,
  input  wire logic [pced_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [pced_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic                            change_summary_flag,
  output logic                            irq,
  output logic                            wake_req
);

  pced_pkg::pced_port_t       pa;
  pced_pkg::pced_port_t       pb;
  logic                       change_irq_enable;
  logic [pced_pkg::EV_W-1:0]  irq_status;
  logic [pced_pkg::EV_W-1:0]  irq_mask;

  logic [7:0]                 pa_rise;
  logic [7:0]                 pa_fall;
  logic [7:0]                 pb_rise;
  logic [7:0]                 pb_fall;
  logic [7:0]                 pa_set;
  logic [7:0]                 pb_set;
  logic [7:0]                 next_pa_flags;
  logic [7:0]                 next_pb_flags;
  logic [pced_pkg::EV_W-1:0]  ev_set;

  logic                       aw_got;
  logic                       w_got;
  logic [pced_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       wr_do;
  logic                       wr_byte;
  logic                       wr_hit;
  pced_pkg::pced_rd_state_t   rd_state;
  logic [31:0]                rd_word;
  logic                       rd_hit;

  // Edge detection cells
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pa
      pced_edge_cell u_cell (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (porta_pin[gi]),
        .rise    (pa_rise[gi]),
        .fall    (pa_fall[gi])
      );
    end
    if (HAS_PORTB) begin : g_pb_on
      for (gi = 0; gi < 8; gi++) begin : g_pb
        pced_edge_cell u_cell (
          .aclk    (aclk),
          .aresetn (aresetn),
          .pin     (portb_pin[gi]),
          .rise    (pb_rise[gi]),
          .fall    (pb_fall[gi])
        );
      end
    end else begin : g_pb_off
      assign pb_rise = pced_pkg::BYTE_ZERO;
      assign pb_fall = pced_pkg::BYTE_ZERO;
    end
  endgenerate

  // Flags set whether or not the interrupt enable is on
  assign pa_set = ((pa_rise & pa.rise) | (pa_fall & pa.fall)) & pced_pkg::PA_MASK;
  assign pb_set = ((pb_rise & pb.rise) | (pb_fall & pb.fall)) & pced_pkg::PB_MASK;

  assign wr_do   = aw_got & w_got & ~s_axi_bvalid;
  assign wr_byte = wr_do & w_strb[0];

  // Set wins over the written value, so no edge is lost while clearing
  always_comb begin
    next_pa_flags = pa.flags;
    next_pb_flags = pb.flags;
    if (wr_byte && aw_addr == pced_pkg::OFF_PA_FLAGS) begin
      next_pa_flags = w_data[7:0];
    end
    if (wr_byte && aw_addr == pced_pkg::OFF_PB_FLAGS) begin
      next_pb_flags = w_data[7:0];
    end
    next_pa_flags = (next_pa_flags | pa_set) & pced_pkg::PA_MASK;
    next_pb_flags = (next_pb_flags | pb_set) & pced_pkg::PB_MASK;
    if (!HAS_PORTB) begin
      next_pb_flags = pced_pkg::BYTE_ZERO;
    end
  end

  assign ev_set[pced_pkg::EV_PA_BIT] = |pa_set;
  assign ev_set[pced_pkg::EV_PB_BIT] = |pb_set;

  // Enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa.rise           <= pced_pkg::PORT_RESET.rise;
      pa.fall           <= pced_pkg::PORT_RESET.fall;
      pb.rise           <= pced_pkg::PORT_RESET.rise;
      pb.fall           <= pced_pkg::PORT_RESET.fall;
      change_irq_enable <= 1'b0;
      irq_mask          <= pced_pkg::EV_ZERO;
    end else if (wr_byte) begin
      if (aw_addr == pced_pkg::OFF_PA_RISE) begin
        pa.rise <= w_data[7:0] & pced_pkg::PA_MASK;
      end else if (aw_addr == pced_pkg::OFF_PA_FALL) begin
        pa.fall <= w_data[7:0] & pced_pkg::PA_MASK;
      end else if (aw_addr == pced_pkg::OFF_PB_RISE && HAS_PORTB) begin
        pb.rise <= w_data[7:0] & pced_pkg::PB_MASK;
      end else if (aw_addr == pced_pkg::OFF_PB_FALL && HAS_PORTB) begin
        pb.fall <= w_data[7:0] & pced_pkg::PB_MASK;
      end else if (aw_addr == pced_pkg::OFF_ICR) begin
        change_irq_enable <= w_data[pced_pkg::ICR_EN_BIT];
      end else if (aw_addr == pced_pkg::OFF_IRQ_MASK) begin
        irq_mask <= w_data[pced_pkg::EV_W-1:0];
      end
    end
  end

  // Flags, summary, event status and request outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa.flags            <= pced_pkg::PORT_RESET.flags;
      pb.flags            <= pced_pkg::PORT_RESET.flags;
      change_summary_flag <= 1'b0;
      irq_status          <= pced_pkg::EV_ZERO;
      irq                 <= 1'b0;
      wake_req            <= 1'b0;
    end else begin
      pa.flags            <= next_pa_flags;
      pb.flags            <= next_pb_flags;
      change_summary_flag <= |{next_pa_flags, next_pb_flags};
      if (wr_byte && aw_addr == pced_pkg::OFF_IRQ_STAT) begin
        irq_status <= (irq_status & ~w_data[pced_pkg::EV_W-1:0]) | ev_set;
      end else begin
        irq_status <= irq_status | ev_set;
      end
      // Enable gates only the request, never the detection
      irq      <= (change_irq_enable & change_summary_flag) | (|(irq_status & irq_mask));
      // Follows the summary, so the flags are already updated when wake rises
      wake_req <= change_irq_enable & change_summary_flag;
    end
  end

  // AXI4-Lite write channel: address and data taken in either order
  assign wr_hit = aw_addr == pced_pkg::OFF_PA_RISE || aw_addr == pced_pkg::OFF_PA_FALL ||
                  aw_addr == pced_pkg::OFF_PA_FLAGS || aw_addr == pced_pkg::OFF_PB_RISE ||
                  aw_addr == pced_pkg::OFF_PB_FALL || aw_addr == pced_pkg::OFF_PB_FLAGS ||
                  aw_addr == pced_pkg::OFF_ICR || aw_addr == pced_pkg::OFF_IRQ_STAT ||
                  aw_addr == pced_pkg::OFF_IRQ_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= pced_pkg::BYTE_ZERO;
      w_data        <= pced_pkg::WORD_ZERO;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pced_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got        <= 1'b1;
        aw_addr       <= {s_axi_awaddr[pced_pkg::ADDR_W-1:2], 2'h0};
        s_axi_awready <= 1'b0;
      end else if (!aw_got && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_got && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_do) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? pced_pkg::RESP_OKAY : pced_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode; unmapped addresses answer with SLVERR and zero data
  always_comb begin
    rd_word = pced_pkg::WORD_ZERO;
    rd_hit  = 1'b1;
    if (s_axi_araddr[pced_pkg::ADDR_W-1:2] == pced_pkg::OFF_PA_RISE[pced_pkg::ADDR_W-1:2]) begin
      rd_word[7:0] = pa.rise;
    end else if (s_axi_araddr[pced_pkg::ADDR_W-1:2] == pced_pkg::OFF_PA_FALL[pced_pkg::ADDR_W-1:2]) begin
      rd_word[7:0] = pa.fall;
    end else if (s_axi_araddr[pced_pkg::ADDR_W-1:2] == pced_pkg::OFF_PA_FLAGS[pced_pkg::ADDR_W-1:2]) begin
      rd_word[7:0] = pa.flags;
    end else if (s_axi_araddr[pced_pkg::ADDR_W-1:2] == pced_pkg::OFF_PB_RISE[pced_pkg::ADDR_W-1:2]) begin
      rd_word[7:0] = pb.rise;
    end else if (s_axi_araddr[pced_pkg::ADDR_W-1:2] == pced_pkg::OFF_PB_FALL[pced_pkg::ADDR_W-1:2]) begin
      rd_word[7:0] = pb.fall;
    end else if (s_axi_araddr[pced_pkg::ADDR_W-1:2] == pced_pkg::OFF_PB_FLAGS[pced_pkg::ADDR_W-1:2]) begin
      rd_word[7:0] = pb.flags;
    end else if (s_axi_araddr[pced_pkg::ADDR_W-1:2] == pced_pkg::OFF_ICR[pced_pkg::ADDR_W-1:2]) begin
      rd_word[pced_pkg::ICR_SUM_BIT] = change_summary_flag;
      rd_word[pced_pkg::ICR_EN_BIT]  = change_irq_enable;
    end else if (s_axi_araddr[pced_pkg::ADDR_W-1:2] == pced_pkg::OFF_IRQ_STAT[pced_pkg::ADDR_W-1:2]) begin
      rd_word[pced_pkg::EV_W-1:0] = irq_status;
    end else if (s_axi_araddr[pced_pkg::ADDR_W-1:2] == pced_pkg::OFF_IRQ_MASK[pced_pkg::ADDR_W-1:2]) begin
      rd_word[pced_pkg::EV_W-1:0] = irq_mask;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state      <= pced_pkg::RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= pced_pkg::WORD_ZERO;
      s_axi_rresp   <= pced_pkg::RESP_OKAY;
    end else begin
      case (rd_state)
        pced_pkg::RD_IDLE: begin
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? pced_pkg::RESP_OKAY : pced_pkg::RESP_SLVERR;
            rd_state      <= pced_pkg::RD_DATA;
          end else begin
            s_axi_arready <= 1'b1;
          end
        end
        pced_pkg::RD_DATA: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state     <= pced_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state <= pced_pkg::RD_IDLE;
        end
      endcase
    end
  end

endmodule : pced_top

// File: logic/pced_pkg.sv
// Package with register map, field layout and bus constants of the pin change edge detector
package pced_pkg;

  localparam int ADDR_W = 8;

  localparam logic [7:0] OFF_PA_RISE  = 8'h00;
  localparam logic [7:0] OFF_PA_FALL  = 8'h04;
  localparam logic [7:0] OFF_PA_FLAGS = 8'h08;
  localparam logic [7:0] OFF_PB_RISE  = 8'h0c;
  localparam logic [7:0] OFF_PB_FALL  = 8'h10;
  localparam logic [7:0] OFF_PB_FLAGS = 8'h14;
  localparam logic [7:0] OFF_ICR      = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  // Implemented bit positions of each port
  localparam logic [7:0] PA_MASK = 8'h3b;
  localparam logic [7:0] PB_MASK = 8'hf0;

  localparam int ICR_SUM_BIT = 0;
  localparam int ICR_EN_BIT  = 3;

  localparam int EV_PA_BIT = 0;
  localparam int EV_PB_BIT = 1;
  localparam int EV_W      = 2;

  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0]  EV_ZERO   = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flags;
  } pced_port_t;

  localparam pced_port_t PORT_RESET = '{rise: 8'h00, fall: 8'h00, flags: 8'h00};

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } pced_rd_state_t;

endpackage : pced_pkg

// File: logic/pced_edge_cell.sv
// One monitored pin: two-stage synchroniser and edge detector
`timescale 1ns/1ps
module pced_edge_cell (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic sync_a;
  logic sync_b;
  logic prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  // Compare the settled sample against the one before it
  assign rise = sync_b & ~prev;
  assign fall = ~sync_b & prev;

endmodule : pced_edge_cell

// File: bench/pced_sva.sv
// Checker of bus handshakes and interrupt outputs of the detector
`timescale 1ns/1ps
module pced_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        change_summary_flag,
  input wire logic        irq,
  input wire logic        wake_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_unmapped_rd: assert property (rd_taken and s_axi_araddr[7:2] > 6'h08 |=>
    s_axi_rresp == pced_pkg::RESP_SLVERR && s_axi_rdata == pced_pkg::WORD_ZERO) else $error("unmapped read");
  chk_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready held");
  chk_wake_sum: assert property (wake_req |-> $past(change_summary_flag)) else $error("wake without flag");
  chk_wake_irq: assert property (wake_req |-> irq) else $error("wake without irq");
  chk_sum_fall: assert property ($fell(change_summary_flag) |=> !wake_req) else $error("wake after clear");
endmodule : pced_sva
bind pced_top pced_sva chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .change_summary_flag, .irq, .wake_req);

// File: bench/pced_pin_model.sv
// Behavioural source of the external port pin levels
`timescale 1ns/1ps
module pced_pin_model (
  input  wire logic       aclk,
  input  wire logic [7:0] want_a,
  input  wire logic [7:0] want_b,
  output logic      [7:0] porta_pin,
  output logic      [7:0] portb_pin
);
  // Levels move just after a rising aclk edge, in step with the clock of the sampler
  initial begin
    porta_pin = 8'h00;
    portb_pin = 8'h00;
  end
  always @(posedge aclk) begin
    porta_pin <= want_a;
    portb_pin <= want_b;
  end
endmodule : pced_pin_model

// File: bench/tb.sv
// Self-checking bench of the pin change edge detector
`timescale 1ns/1ps
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] pa = 8'h00, pb = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ea, eb, na, nb;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] r, ev;
  wire logic [7:0] porta_pin, portb_pin;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, change_summary_flag, irq, wake_req;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int n_mismatch = 0, checks_done = 0;
  always #20 aclk = ~aclk;
  pced_pin_model pm_u (.aclk, .want_a(pa), .want_b(pb), .porta_pin, .portb_pin);
  pced_top #(.HAS_PORTB(1'b1)) dut_u (.aclk, .aresetn, .porta_pin, .portb_pin, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .change_summary_flag, .irq, .wake_req);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic hang;
    cmp("wait limit", 32'h1, 32'h0);
    complete_run();
  endtask : hang
  // Readys are looked at mid-cycle: they only change after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    logic ta, tw, ha, hw;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    // Pending flags kept locally: the valids written above are not visible until the update region
    ta = 1'b1;
    tw = 1'b1;
    for (n = 0; ta || tw; n++) begin
      if (n > 50) hang();
      @(negedge aclk);
      ha = ta && s_axi_awready;
      hw = tw && s_axi_wready;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      ta = ta && !ha;
      tw = tw && !hw;
    end
    n = 0;
    do begin if (n++ > 50) hang(); @(negedge aclk); end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    @(posedge aclk); s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk); s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    n = 0;
    do begin if (n++ > 50) hang(); @(negedge aclk); end while (!s_axi_arready);
    @(posedge aclk); s_axi_arvalid <= 1'b0;
    n = 0;
    do begin if (n++ > 50) hang(); @(negedge aclk); end while (!s_axi_rvalid);
    v = s_axi_rdata; rs = s_axi_rresp;
    @(posedge aclk); s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    cmp(nm, e, d);
  endtask : rdc
  function automatic logic [7:0] edges(input logic [7:0] re, fe, o, nw, m);
    return m & ((re & ~o & nw) | (fe & o & ~nw));
  endfunction : edges
  initial begin
    static logic [7:0] offs [4] = '{pced_pkg::OFF_PA_RISE, pced_pkg::OFF_PA_FALL,
                                    pced_pkg::OFF_PB_RISE, pced_pkg::OFF_PB_FALL};
    static logic [7:0] mk [4] = '{pced_pkg::PA_MASK, pced_pkg::PA_MASK, pced_pkg::PB_MASK, pced_pkg::PB_MASK};
    logic [7:0] en [4];
    void'($urandom(52));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 9; i++) rdc("reset value", 8'(i * 4), 32'h0);
    rdc("unmapped read", 8'h40, 32'h0);
    cmp("unmapped rresp", {30'h0, pced_pkg::RESP_SLVERR}, {30'h0, r});
    wr(8'h44, 32'hff, r);
    cmp("unmapped bresp", {30'h0, pced_pkg::RESP_SLVERR}, {30'h0, r});
    // Low byte strobe off: the write must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(pced_pkg::OFF_PA_RISE, 32'hff, r);
    s_axi_wstrb <= 4'hf;
    rdc("strobe off", pced_pkg::OFF_PA_RISE, 32'h0);
    $display("test reset values done");
    ev = 2'h0;
    for (int k = 0; k < 24; k++) begin
      // Both ends of the run force every enable and a toggle of every pin
      wr(pced_pkg::OFF_PA_FLAGS, 32'h0, r);
      wr(pced_pkg::OFF_PB_FLAGS, 32'h0, r);
      for (int j = 0; j < 4; j++) begin
        en[j] = (k == 0 || k == 23) ? 8'hff : 8'($urandom);
        wr(offs[j], {24'h0, en[j]}, r);
        rdc("enable readback", offs[j], {24'h0, en[j] & mk[j]});
      end
      na = (k == 0 || k == 23) ? ~pa : 8'($urandom);
      nb = (k == 0 || k == 23) ? ~pb : 8'($urandom);
      ea = edges(en[0], en[1], pa, na, pced_pkg::PA_MASK);
      eb = edges(en[2], en[3], pb, nb, pced_pkg::PB_MASK);
      ev = ev | {|eb, |ea};
      @(posedge aclk);
      pa <= na;
      pb <= nb;
      repeat (8) @(posedge aclk);
      rdc("porta flags", pced_pkg::OFF_PA_FLAGS, {24'h0, ea});
      rdc("portb flags", pced_pkg::OFF_PB_FLAGS, {24'h0, eb});
      rdc("summary bit", pced_pkg::OFF_ICR, {31'h0, |{ea, eb}});
      cmp("summary flag", {31'h0, |{ea, eb}}, {31'h0, change_summary_flag});
    end
    $display("test edge detection done");
    rdc("irq status", pced_pkg::OFF_IRQ_STAT, {30'h0, ev});
    cmp("irq masked", 32'h0, {31'h0, irq});
    wr(pced_pkg::OFF_IRQ_MASK, 32'h3, r);
    repeat (3) @(negedge aclk);
    cmp("irq unmasked", 32'h1, {31'h0, irq});
    wr(pced_pkg::OFF_IRQ_STAT, 32'h3, r);
    rdc("irq status cleared", pced_pkg::OFF_IRQ_STAT, 32'h0);
    repeat (3) @(negedge aclk);
    cmp("irq after clear", 32'h0, {31'h0, irq});
    rdc("flags kept", pced_pkg::OFF_PA_FLAGS, {24'h0, pced_pkg::PA_MASK});
    wr(pced_pkg::OFF_ICR, 32'h8, r);
    repeat (3) @(negedge aclk);
    cmp("wake", 32'h1, {31'h0, wake_req});
    cmp("irq enabled", 32'h1, {31'h0, irq});
    $display("test interrupt done");
    wr(pced_pkg::OFF_PA_FLAGS, 32'h0, r);
    wr(pced_pkg::OFF_PB_FLAGS, 32'h0, r);
    repeat (3) @(negedge aclk);
    cmp("summary cleared", 32'h0, {31'h0, change_summary_flag});
    cmp("wake cleared", 32'h0, {31'h0, wake_req});
    @(posedge aclk);
    pa <= ~pa;
    // One spare edge lands the clearing write on the same edge that sets the flags
    @(posedge aclk);
    wr(pced_pkg::OFF_PA_FLAGS, 32'h0, r);
    repeat (8) @(posedge aclk);
    rdc("flag during clear", pced_pkg::OFF_PA_FLAGS, {24'h0, pced_pkg::PA_MASK});
    $display("test clearing done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc("rise after reset", pced_pkg::OFF_PA_RISE, 32'h0);
    rdc("flags after reset", pced_pkg::OFF_PA_FLAGS, 32'h0);
    cmp("summary after reset", 32'h0, {31'h0, change_summary_flag});
    $display("test second reset done");
    complete_run();
  end
endmodule : tb
